/* rtl/sfp_pkg.sv */
`default_nettype none
package sfp_pkg;
  // ==========================================================
  // clocking
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCLK_PERIOD_NS = 400;
  localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int SCLK_CNT_W = 8;
  // ==========================================================
  // header byte layout and addresses
  localparam int HDR_RW_BIT = 7;
  localparam int HDR_BURST_BIT = 6;
  localparam logic [5:0] FIFO_ADDR = 6'h3f;
  localparam logic [5:0] PA_ADDR = 6'h3e;
  localparam logic [5:0] STROBE_LO_ADDR = 6'h30;
  localparam logic [5:0] STROBE_HI_ADDR = 6'h3d;
  localparam logic [5:0] FLUSH_RX_ADDR = 6'h3a;
  localparam logic [5:0] FLUSH_TX_ADDR = 6'h3b;
  // ==========================================================
  // status byte and main states
  localparam logic [2:0] MS_IDLE = 3'h0;
  localparam logic [2:0] MS_RX_OVERFLOW = 3'h6;
  localparam logic [2:0] MS_TX_UNDERFLOW = 3'h7;
  localparam logic [6:0] CNT_SAT = 7'h0f;
  // ==========================================================
  // buffers, power table, status pins
  localparam int FIFO_AW = 6;
  localparam int FIFO_DEPTH = 64;
  localparam logic [6:0] FIFO_DEPTH_CNT = 7'h40;
  localparam int PA_ENTRIES = 2;
  localparam logic [7:0] PA_RESET = 8'h00;
  localparam int SEL_W = 4;
  localparam int SRC_W = 16;
  localparam logic [3:0] SHARED_HIZ_SEL = 4'hf;
  // ==========================================================
  // host command port map
  localparam logic [1:0] HREG_BYTE = 2'h0;
  localparam logic [1:0] HREG_CTRL = 2'h1;
  localparam logic [1:0] HREG_STATUS = 2'h2;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int CTRL_PIN0_OE_BIT = 1;
  localparam int CTRL_PIN0_VAL_BIT = 2;
  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_SETUP = 5'h02,
    H_HIGH = 5'h04,
    H_LOW = 5'h08,
    H_GAP = 5'h10
  } sfp_hstate_t;
endpackage
`default_nettype wire

/* rtl/sfp_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sfp_link_if;
  logic sclk;
  logic chip_select_low;
  logic mosi;
  logic dev_miso_o;
  logic dev_miso_oe;
  logic dev_pin0_o;
  logic dev_pin0_oe;
  logic host_pin0_o;
  logic host_pin0_oe;
  logic status_pin_two;
  logic shared_pin_level;
  logic pin0_level;
  // ==========================================================
  // wire resolution, pulled up when undriven
  assign shared_pin_level = dev_miso_oe ? dev_miso_o : 1'b1;
  assign pin0_level = dev_pin0_oe ? dev_pin0_o : (host_pin0_oe ? host_pin0_o : 1'b1);
  modport device (
    input sclk, chip_select_low, mosi, pin0_level,
    output dev_miso_o, dev_miso_oe, dev_pin0_o, dev_pin0_oe, status_pin_two
  );
  modport host (
    output sclk, chip_select_low, mosi, host_pin0_o, host_pin0_oe,
    input shared_pin_level, pin0_level, status_pin_two
  );
endinterface
`default_nettype wire

/* rtl/sfp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module sfp_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_r;
  // ==========================================================
  // two-stage synchroniser
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* rtl/sfp_device.sv */
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sfp_device
  import sfp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  sfp_link_if.device link,
  input wire logic [2:0] main_state_in,
  input wire logic chip_ready_in,
  input wire logic sleep_in,
  input wire logic tx_pop_in,
  output logic [7:0] tx_data_out,
  output logic tx_empty_out,
  input wire logic rx_push_in,
  input wire logic [7:0] rx_data_in,
  output logic rx_full_out,
  input wire logic [SRC_W-1:0] status_src_in,
  input wire logic [SEL_W-1:0] sel_zero_in,
  input wire logic [SEL_W-1:0] sel_two_in,
  input wire logic [SEL_W-1:0] sel_shared_in,
  input wire logic serial_mode_in,
  input wire logic tx_active_in,
  output logic serial_tx_data_out
);
  // ==========================================================
  // pin synchronisers and edge detection
  logic [3:0] sync_q;
  logic sclk_s;
  logic csl_s;
  logic mosi_s;
  logic sclk_d_r;
  logic csl_d_r;
  sfp_sync #(.W(4)) u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .d_in({link.sclk, ~link.chip_select_low, link.mosi, link.pin0_level}),
    .q_out(sync_q)
  );
  // select passes inverted so that reset reads as deselected
  assign sclk_s = sync_q[3];
  assign csl_s = ~sync_q[2];
  assign mosi_s = sync_q[1];
  assign serial_tx_data_out = sync_q[0];
  wire sclk_rise = sclk_s & ~sclk_d_r & ~csl_s;
  wire sclk_fall = ~sclk_s & sclk_d_r & ~csl_s;
  wire cs_fall = ~csl_s & csl_d_r;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sclk_d_r <= 1'b0;
      csl_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      csl_d_r <= csl_s;
    end
  end
  // ==========================================================
  // byte framing and header decode
  logic [2:0] bit_cnt_r;
  logic [7:0] in_sh_r;
  logic [7:0] out_sh_r;
  logic [7:0] pend_r;
  logic in_data_r;
  logic hdr_rw_r;
  logic hdr_burst_r;
  logic [5:0] hdr_addr_r;
  logic pa_idx_r;
  logic sleep_d_r;
  wire byte_done = sclk_rise & (bit_cnt_r == 3'h7);
  wire [7:0] byte_val = {in_sh_r[6:0], mosi_s};
  wire h_rw = byte_val[HDR_RW_BIT];
  wire h_burst = byte_val[HDR_BURST_BIT];
  wire [5:0] h_addr = byte_val[5:0];
  wire is_hdr = byte_done & ~in_data_r;
  wire data_done = byte_done & in_data_r;
  wire hdr_fifo = is_hdr & (h_addr == FIFO_ADDR);
  wire hdr_pa = is_hdr & (h_addr == PA_ADDR);
  wire hdr_strobe = is_hdr & ~h_burst & (h_addr >= STROBE_LO_ADDR) & (h_addr <= STROBE_HI_ADDR);
  wire cur_fifo = hdr_addr_r == FIFO_ADDR;
  wire cur_pa = hdr_addr_r == PA_ADDR;
  // ==========================================================
  // flush and sleep
  wire sleep_entry = sleep_in & ~sleep_d_r;
  wire flush_ok = (main_state_in == MS_IDLE) | (main_state_in == MS_RX_OVERFLOW)
    | (main_state_in == MS_TX_UNDERFLOW);
  wire flush_tx = (hdr_strobe & (h_addr == FLUSH_TX_ADDR) & flush_ok) | sleep_entry;
  wire flush_rx = (hdr_strobe & (h_addr == FLUSH_RX_ADDR) & flush_ok) | sleep_entry;
  // ==========================================================
  // buffer storage and counts
  logic [7:0] tx_mem [FIFO_DEPTH];
  logic [7:0] rx_mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] tx_wp_r;
  logic [FIFO_AW-1:0] tx_rp_r;
  logic [FIFO_AW-1:0] rx_wp_r;
  logic [FIFO_AW-1:0] rx_rp_r;
  logic [6:0] tx_cnt_r;
  logic [6:0] rx_cnt_r;
  logic [7:0] pa_table_r [PA_ENTRIES];
  wire tx_full = tx_cnt_r == FIFO_DEPTH_CNT;
  wire rx_empty = rx_cnt_r == 7'h00;
  assign tx_empty_out = tx_cnt_r == 7'h00;
  assign rx_full_out = rx_cnt_r == FIFO_DEPTH_CNT;
  assign tx_data_out = tx_mem[tx_rp_r];
  wire tx_push = data_done & ~hdr_rw_r & cur_fifo & ~tx_full;
  wire tx_pop = tx_pop_in & ~tx_empty_out;
  wire rx_push = rx_push_in & ~rx_full_out;
  wire rd_fifo = (hdr_fifo & h_rw) | (data_done & hdr_rw_r & hdr_burst_r & cur_fifo);
  wire rd_pa = (hdr_pa & h_rw) | (data_done & hdr_rw_r & hdr_burst_r & cur_pa);
  wire pa_wr = data_done & ~hdr_rw_r & cur_pa;
  wire rx_pop = rd_fifo & ~rx_empty;
  wire [6:0] tx_free = FIFO_DEPTH_CNT - tx_cnt_r - {6'h00, tx_push};
  wire [6:0] tx_cnt_nxt = tx_cnt_r + {6'h00, tx_push} - {6'h00, tx_pop};
  wire [6:0] rx_cnt_nxt = rx_cnt_r + {6'h00, rx_push} - {6'h00, rx_pop};
  function automatic logic [3:0] sat_cnt(input logic [6:0] c);
    sat_cnt = (c > CNT_SAT) ? 4'hf : c[3:0];
  endfunction
  always_ff @(posedge clk_in) begin
    if (tx_push) begin
      tx_mem[tx_wp_r] <= byte_val;
    end
    if (rx_push) begin
      rx_mem[rx_wp_r] <= rx_data_in;
    end
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_cnt_r <= 7'h00;
    end else if (flush_tx) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_cnt_r <= 7'h00;
    end else begin
      tx_wp_r <= tx_wp_r + FIFO_AW'(tx_push);
      tx_rp_r <= tx_rp_r + FIFO_AW'(tx_pop);
      tx_cnt_r <= tx_cnt_nxt;
    end
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_cnt_r <= 7'h00;
    end else if (flush_rx) begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_cnt_r <= 7'h00;
    end else begin
      rx_wp_r <= rx_wp_r + FIFO_AW'(rx_push);
      rx_rp_r <= rx_rp_r + FIFO_AW'(rx_pop);
      rx_cnt_r <= rx_cnt_nxt;
    end
  end
  // ==========================================================
  // power level table
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pa_table_r[0] <= PA_RESET;
      pa_table_r[1] <= PA_RESET;
      pa_idx_r <= 1'b0;
      sleep_d_r <= 1'b0;
    end else begin
      sleep_d_r <= sleep_in;
      if (pa_wr) begin
        pa_table_r[pa_idx_r] <= byte_val;
      end else if (sleep_entry) begin
        pa_table_r[1] <= PA_RESET;
      end
      if (csl_s) begin
        pa_idx_r <= 1'b0;
      end else if (pa_wr | rd_pa) begin
        pa_idx_r <= ~pa_idx_r;
      end
    end
  end
  // ==========================================================
  // shift registers and access phase
  wire status_rw = is_hdr ? h_rw : hdr_rw_r;
  wire [3:0] cnt_field = status_rw ? sat_cnt(rx_cnt_r) : sat_cnt(tx_free);
  wire [7:0] status_byte = {~chip_ready_in, main_state_in, cnt_field};
  wire [7:0] next_out = rd_fifo ? rx_mem[rx_rp_r] : (rd_pa ? pa_table_r[pa_idx_r] : status_byte);
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bit_cnt_r <= 3'h0;
      in_sh_r <= 8'h00;
      out_sh_r <= 8'h00;
      pend_r <= 8'h00;
    end else begin
      if (csl_s) begin
        bit_cnt_r <= 3'h0;
      end else if (sclk_rise) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
        in_sh_r <= byte_val;
      end
      // next byte waits for the eighth fall so the last bit stands its full phase
      if (byte_done) begin
        pend_r <= next_out;
      end
      if (cs_fall) begin
        out_sh_r <= next_out;
      end else if (sclk_fall & (bit_cnt_r == 3'h0)) begin
        out_sh_r <= pend_r;
      end else if (sclk_fall) begin
        out_sh_r <= {out_sh_r[6:0], 1'b0};
      end
    end
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      in_data_r <= 1'b0;
      hdr_rw_r <= 1'b0;
      hdr_burst_r <= 1'b0;
      hdr_addr_r <= 6'h00;
    end else if (csl_s) begin
      in_data_r <= 1'b0;
    end else if (is_hdr) begin
      in_data_r <= ~hdr_strobe;
      hdr_rw_r <= h_rw;
      hdr_burst_r <= h_burst;
      hdr_addr_r <= h_addr;
    end else if (data_done) begin
      in_data_r <= hdr_burst_r;
    end
  end
  // ==========================================================
  // status pins
  logic pin0_r;
  logic pin2_r;
  logic shared_r;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin0_r <= 1'b0;
      pin2_r <= 1'b0;
      shared_r <= 1'b0;
    end else begin
      pin0_r <= status_src_in[sel_zero_in];
      pin2_r <= status_src_in[sel_two_in];
      shared_r <= status_src_in[sel_shared_in];
    end
  end
  assign link.status_pin_two = pin2_r;
  assign link.dev_pin0_o = pin0_r;
  assign link.dev_pin0_oe = ~(serial_mode_in & tx_active_in);
  assign link.dev_miso_o = csl_s ? shared_r : out_sh_r[7];
  assign link.dev_miso_oe = ~csl_s | (sel_shared_in != SHARED_HIZ_SEL);
endmodule
`default_nettype wire

/* rtl/sfp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sfp_host
  import sfp_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  sfp_link_if.host link,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out
);
  // ==========================================================
  // input synchronisers
  logic [2:0] sync_q;
  sfp_sync #(.W(3)) u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .d_in({link.shared_pin_level, link.pin0_level, link.status_pin_two}),
    .q_out(sync_q)
  );
  // ==========================================================
  // command port decode
  sfp_hstate_t state_r;
  logic [SCLK_CNT_W-1:0] cnt_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] tx_sh_r;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_byte_r;
  logic sclk_r;
  logic csl_r;
  logic hold_r;
  logic pin0_oe_r;
  logic pin0_val_r;
  wire busy = state_r != H_IDLE;
  wire tick = cnt_r == SCLK_CNT_W'(HALF_CYC - 1);
  wire wr_byte = wr_in & (addr_in == HREG_BYTE) & ~busy;
  wire wr_ctrl = wr_in & (addr_in == HREG_CTRL);
  wire release_now = wr_ctrl & ~wdata_in[CTRL_HOLD_BIT] & ~busy & ~csl_r;
  wire [7:0] status_val = {3'h0, sync_q[0], sync_q[1], sync_q[2], ~csl_r, busy};
  wire [7:0] ctrl_val = {5'h00, pin0_val_r, pin0_oe_r, hold_r};
  wire [7:0] rd_mux = (addr_in == HREG_BYTE) ? rx_byte_r :
    (addr_in == HREG_CTRL) ? ctrl_val :
    (addr_in == HREG_STATUS) ? status_val : 8'h00;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= 8'h00;
      hold_r <= 1'b0;
      pin0_oe_r <= 1'b0;
      pin0_val_r <= 1'b0;
    end else begin
      rdata_out <= rd_in ? rd_mux : 8'h00;
      if (wr_ctrl) begin
        hold_r <= wdata_in[CTRL_HOLD_BIT];
        pin0_oe_r <= wdata_in[CTRL_PIN0_OE_BIT];
        pin0_val_r <= wdata_in[CTRL_PIN0_VAL_BIT];
      end
    end
  end
  assign link.host_pin0_oe = pin0_oe_r;
  assign link.host_pin0_o = pin0_val_r;
  assign link.sclk = sclk_r;
  assign link.chip_select_low = csl_r;
  assign link.mosi = tx_sh_r[7];
  // ==========================================================
  // byte engine
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= H_IDLE;
      cnt_r <= '0;
      bit_cnt_r <= 3'h0;
      tx_sh_r <= 8'h00;
      rx_sh_r <= 8'h00;
      rx_byte_r <= 8'h00;
      sclk_r <= 1'b0;
      csl_r <= 1'b1;
    end else begin
      cnt_r <= (tick | ~busy) ? '0 : cnt_r + SCLK_CNT_W'(1);
      unique case (state_r)
        H_IDLE: begin
          if (wr_byte) begin
            tx_sh_r <= wdata_in;
            csl_r <= 1'b0;
            bit_cnt_r <= 3'h0;
            state_r <= H_SETUP;
          end else if (release_now) begin
            csl_r <= 1'b1;
            state_r <= H_GAP;
          end
        end
        H_SETUP: begin
          if (tick) begin
            sclk_r <= 1'b1;
            state_r <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tick) begin
            rx_sh_r <= {rx_sh_r[6:0], sync_q[2]};
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            sclk_r <= 1'b0;
            state_r <= H_LOW;
          end
        end
        H_LOW: begin
          if (tick) begin
            if (bit_cnt_r != 3'h0) begin
              sclk_r <= 1'b1;
              state_r <= H_HIGH;
            end else if (hold_r) begin
              rx_byte_r <= rx_sh_r;
              state_r <= H_IDLE;
            end else begin
              rx_byte_r <= rx_sh_r;
              csl_r <= 1'b1;
              state_r <= H_GAP;
            end
          end
        end
        H_GAP: begin
          if (tick) begin
            state_r <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* verification/sfp_link_props.sv */
`timescale 1ns/1ps
`default_nettype none
module sfp_link_props (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic sclk,
  input wire logic chip_select_low,
  input wire logic mosi,
  input wire logic dev_miso_oe,
  input wire logic dev_pin0_oe,
  input wire logic host_pin0_oe
);
  // ==========================================================
  // clock rises counted within one frame
  logic sclk_q;
  logic [15:0] rise_cnt;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sclk_q <= 1'b0;
      rise_cnt <= 16'h0;
    end else begin
      sclk_q <= sclk;
      rise_cnt <= chip_select_low ? 16'h0 : rise_cnt + {15'h0, sclk & ~sclk_q};
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ==========================================================
  // link framing and pin ownership
  a_sclk_idle_low: assert property (chip_select_low |-> !sclk)
    else $error("serial clock high outside a frame");
  a_sclk_half_period: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high phase not eight cycles");
  a_cs_setup_time: assert property ($fell(chip_select_low) |-> (!sclk) [*8])
    else $error("serial clock rose too soon after select");
  a_cs_frame_gap: assert property ($rose(chip_select_low) |-> chip_select_low [*8])
    else $error("select gap shorter than eight cycles");
  a_mosi_stable_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("data in changed while clock high");
  a_frame_whole_bytes: assert property ($rose(chip_select_low) |-> rise_cnt[2:0] == 3'h0 && rise_cnt != 16'h0)
    else $error("frame not a whole number of bytes");
  a_miso_drive_sel: assert property ((!chip_select_low) [*5] |-> dev_miso_oe)
    else $error("shared pin not driven while selected");
  a_pin0_release: assert property (host_pin0_oe |-> !dev_pin0_oe)
    else $error("pin zero driven by both ends");
  c_frame_start: cover property ($fell(chip_select_low));
  c_burst_frame: cover property ($rose(chip_select_low) && rise_cnt >= 16'h10);
  c_host_pin0: cover property (host_pin0_oe);
endmodule
`default_nettype wire

/* verification/spi_fifo_and_power_table_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_fifo_and_power_table_port_tb;
  import sfp_pkg::*;
  typedef struct packed {logic [2:0] st; logic rdy; logic [7:0] hdr; logic [7:0] dat; logic on; logic [7:0] exp;} sfp_row_t;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdo;
  logic [2:0] mst = MS_IDLE;
  logic rdy = 1'b1;
  logic slp = 1'b0;
  logic pop = 1'b0;
  logic push = 1'b0;
  logic [7:0] rxd = 8'h00;
  logic [15:0] src = 16'h0000;
  logic [3:0] s0 = 4'h0;
  logic [3:0] s2 = 4'h0;
  logic [3:0] ssh = SHARED_HIZ_SEL;
  logic smode = 1'b0;
  logic tact = 1'b0;
  logic [7:0] txd;
  logic txe;
  logic rxf;
  logic stx;
  logic p0e = 1'b0;
  logic p0v = 1'b0;
  logic [7:0] fb[$];
  logic [7:0] fr[$];
  int n_mismatch = 0;
  int num_checks = 0;
  sfp_row_t rows[7] = '{'{MS_IDLE, 1'b1, 8'hbe, 8'h00, 1'b1, 8'h00}, '{MS_IDLE, 1'b1, 8'h3e, 8'h5a, 1'b0, 8'h00},
    '{MS_IDLE, 1'b1, 8'hbe, 8'h00, 1'b1, 8'h5a}, '{MS_IDLE, 1'b1, 8'hbf, 8'h00, 1'b1, 8'ha5},
    '{MS_IDLE, 1'b1, 8'hff, 8'h00, 1'b1, 8'h3c}, '{MS_RX_OVERFLOW, 1'b1, 8'h3f, 8'h11, 1'b1, 8'h6f},
    '{MS_TX_UNDERFLOW, 1'b0, 8'h3f, 8'h22, 1'b1, 8'hff}};
  logic [2:0] fst[4] = '{3'h2, MS_IDLE, MS_RX_OVERFLOW, MS_TX_UNDERFLOW};
  logic [15:0] pat[2] = '{16'h0208, 16'hfdf7};
  always #12.5 clk_in = ~clk_in;
  sfp_link_if lk();
  sfp_device sfp_device_i(.clk_in(clk_in), .rst_b_in(rst_b_in), .link(lk), .main_state_in(mst), .chip_ready_in(rdy),
    .sleep_in(slp), .tx_pop_in(pop), .tx_data_out(txd), .tx_empty_out(txe), .rx_push_in(push), .rx_data_in(rxd),
    .rx_full_out(rxf), .status_src_in(src), .sel_zero_in(s0), .sel_two_in(s2), .sel_shared_in(ssh),
    .serial_mode_in(smode), .tx_active_in(tact), .serial_tx_data_out(stx));
  sfp_host sfp_host_i(.clk_in(clk_in), .rst_b_in(rst_b_in), .link(lk), .addr_in(addr), .wdata_in(wd), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdo));
  sfp_link_props sfp_link_props_i(.clk_in(clk_in), .rst_b_in(rst_b_in), .sclk(lk.sclk),
    .chip_select_low(lk.chip_select_low), .mosi(lk.mosi), .dev_miso_oe(lk.dev_miso_oe),
    .dev_pin0_oe(lk.dev_pin0_oe), .host_pin0_oe(lk.host_pin0_oe));
  // ==========================================================
  // command port and link tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdo;
  endtask
  task automatic frame();
    logic [7:0] s;
    logic [7:0] r;
    fr = {};
    foreach (fb[i]) begin
      if (i == 0) wr_reg(HREG_CTRL, {5'h0, p0v, p0e, fb.size() > 1});
      wr_reg(HREG_BYTE, fb[i]);
      if (i != 0 && i == fb.size() - 1) wr_reg(HREG_CTRL, {5'h0, p0v, p0e, 1'b0});
      s = 8'h01;
      for (int n = 0; n < 400 && s[0] !== 1'b0; n++) rd_reg(HREG_STATUS, s);
      chk(s[0], 1'b0);
      rd_reg(HREG_BYTE, r);
      fr.push_back(r);
    end
  endtask
  task automatic push_rx(input logic [7:0] d);
    @(posedge clk_in);
    rxd <= d;
    push <= 1'b1;
    @(posedge clk_in);
    push <= 1'b0;
  endtask
  task automatic pop_tx();
    @(posedge clk_in);
    pop <= 1'b1;
    @(posedge clk_in);
    pop <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(80000 * 25);
    n_mismatch++;
    finish_test();
  end
  // ==========================================================
  // test sequence
  initial begin
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk(txe, 1'b1);
    chk(rxf, 1'b0);
    push_rx(8'ha5);
    push_rx(8'h3c);
    foreach (rows[i]) begin
      @(posedge clk_in);
      mst <= rows[i].st;
      rdy <= rows[i].rdy;
      fb = '{rows[i].hdr, rows[i].dat};
      frame();
      if (rows[i].on) chk(fr[1], rows[i].exp);
    end
    @(posedge clk_in);
    mst <= MS_IDLE;
    rdy <= 1'b1;
    chk(lk.dev_miso_oe, 1'b0);
    chk(lk.shared_pin_level, 1'b1);
    @(posedge clk_in);
    ssh <= 4'h3;
    s2 <= 4'h5;
    s0 <= 4'h9;
    foreach (pat[k]) begin
      @(posedge clk_in) src <= pat[k];
      repeat (8) @(posedge clk_in);
      chk({lk.shared_pin_level, lk.status_pin_two, lk.pin0_level}, {pat[k][3], pat[k][5], pat[k][9]});
    end
    fb = '{8'h3f, 8'h44, 8'h3f, 8'h55};
    frame();
    chk(fr[3], 8'h0f);
    fb = '{8'h11, 8'h22, 8'h44, 8'h55};
    foreach (fb[i]) begin
      chk(txd, fb[i]);
      pop_tx();
    end
    fb = '{8'h7f};
    for (int k = 0; k < 65; k++) fb.push_back(8'(k));
    frame();
    for (int k = 0; k < 65; k++) chk(fr[k + 1], k == 64 ? 8'h00 : (64 - k > 15 ? 8'h0f : 8'(64 - k)));
    for (int k = 0; k < 64; k++) begin
      chk(txd, 8'(k));
      pop_tx();
    end
    chk(txe, 1'b1);
    foreach (fst[k]) begin
      push_rx(8'h77);
      fb = '{8'h3f, 8'h66};
      frame();
      @(posedge clk_in) mst <= fst[k];
      fb = '{8'h3a, 8'h3b};
      frame();
      chk(txe, k != 0);
      @(posedge clk_in) mst <= MS_IDLE;
      push_rx(8'h99);
      fb = '{8'hbf, 8'h00};
      frame();
      chk(fr[1], k != 0 ? 8'h99 : 8'h77);
    end
    fb = '{8'h7e, 8'h12, 8'h34};
    frame();
    fb = '{8'hfe, 8'h00, 8'h00};
    frame();
    chk({fr[1], fr[2]}, 16'h1234);
    push_rx(8'h55);
    fb = '{8'h3f, 8'h66};
    frame();
    chk(txe, 1'b0);
    @(posedge clk_in) slp <= 1'b1;
    repeat (6) @(posedge clk_in);
    slp <= 1'b0;
    chk(txe, 1'b1);
    fb = '{8'hfe, 8'h00, 8'h00};
    frame();
    chk({fr[1], fr[2]}, 16'h1200);
    push_rx(8'h99);
    fb = '{8'hbf, 8'h00};
    frame();
    chk(fr[1], 8'h99);
    @(posedge clk_in) smode <= 1'b1;
    tact <= 1'b1;
    repeat (8) @(posedge clk_in);
    p0e = 1'b1;
    for (int v = 0; v < 2; v++) begin
      p0v = v[0];
      wr_reg(HREG_CTRL, {5'h0, p0v, p0e, 1'b0});
      repeat (8) @(posedge clk_in);
      chk(stx, v[0]);
    end
    p0e = 1'b0;
    wr_reg(HREG_CTRL, 8'h00);
    repeat (8) @(posedge clk_in);
    wr_reg(HREG_CTRL, 8'h01);
    wr_reg(HREG_BYTE, 8'h3b);
    repeat (160) @(posedge clk_in);
    chk(lk.chip_select_low, 1'b0);
    wr_reg(HREG_CTRL, 8'h00);
    repeat (2) @(posedge clk_in);
    chk(lk.chip_select_low, 1'b1);
    repeat (10) @(posedge clk_in);
    finish_test();
  end
endmodule
`default_nettype wire
